/* rtl/timer2_pkg.sv */
// Constants shared by the timer 2 / baud clock block and its helpers.
// Assumes an 8-bit special function register port on the oscillator clock.
//
// Summary of operation
// - Two outputs invert their level on each overflow of timer 0 and timer 1.
// - A per-timer select bit drives its pin from port latch or toggle.
// - Timer 2 is 16 bits and times ticks or counts external falling edges.
// - Outside baud generation, every timer 2 overflow or underflow sets the overflow flag.
// - Capture mode without external enable is a plain 16-bit timer.
// - Capture mode with enable: pin falling edge copies count, sets external flag.
// - The external flag raises the timer 2 interrupt like the overflow flag.
// - Auto-reload loads the count from the reload pair on overflow.
// - Up-only auto-reload with enable: pin falling edge reloads, sets external flag.
// - With down-count enabled the pin level picks direction: high up, low down.
// - Counting up, overflow after FFFFH sets the flag and reloads.
// - Counting down, each count compares the timer with the reload pair.
// - UART modes 0 and 2 use fixed division; modes 1 and 3 timer overflows.
// - Bit clock is sixteen times baud: fixed osc/16 in mode 0, osc/32 mode 2.
// - Shared prescaler code: 00 osc/4, 01 osc/16, 10 osc/64, 11 reserved.
// - Timer 2 counting up reloads from the reload pair on overflow for baud generation.
// - Bits 5 and 4 of control and mode registers route timer 2 to UARTs.
// - As baud generator timer 2 increments at the prescaled tick.
// - A UART not routed to timer 2 keeps timer 1 or its fixed clock.

package timer2_pkg;

   localparam logic [10:0] TIMER_EXTENDED_STATUS_ADDR   = 11'h411;
   localparam logic [10:0] TIMER2_CONTROL_ADDR          = 11'h418;
   localparam logic [10:0] TIMER2_MODE_CONTROL_ADDR     = 11'h419;
   localparam logic [10:0] SYSTEM_CONFIG_PRESCALER_ADDR = 11'h440;
   localparam logic [10:0] TIMER_LOW_BYTE_ADDR          = 11'h458;
   localparam logic [10:0] TIMER_HIGH_BYTE_ADDR         = 11'h459;
   localparam logic [10:0] RELOAD_LOW_BYTE_ADDR         = 11'h45A;
   localparam logic [10:0] RELOAD_HIGH_BYTE_ADDR        = 11'h45B;

   // Control register fields
   localparam int OVF_FLAG_BIT    = 7;
   localparam int EXT_FLAG_BIT    = 6;
   localparam int UART_A_RX_BIT   = 5;
   localparam int UART_A_TX_BIT   = 4;
   localparam int EXT_EN_BIT      = 3;
   localparam int RUN_BIT         = 2;
   localparam int CT_SEL_BIT      = 1;
   localparam int CAP_RL_BIT      = 0;
   // Mode register fields
   localparam int UART_B_RX_BIT   = 5;
   localparam int UART_B_TX_BIT   = 4;
   localparam int CLK_OUT_BIT     = 1;
   localparam int DOWN_EN_BIT     = 0;
   // Prescaler field and extended status fields
   localparam int PRESC_LOW_BIT   = 2;
   localparam int T0_OUT_SEL_BIT  = 0;
   localparam int T1_OUT_SEL_BIT  = 2;

   // Implemented bits; the rest read as zero
   localparam logic [7:0] MODE_MASK   = 8'h33;
   localparam logic [7:0] PRESC_MASK  = 8'h0C;
   localparam logic [7:0] STATUS_MASK = 8'h05;

   localparam logic [7:0]  REG_RESET   = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] TIMER_MAX   = 16'hFFFF;

   localparam logic [1:0] PRESC_DIV4  = 2'h0;
   localparam logic [1:0] PRESC_DIV16 = 2'h1;
   localparam logic [1:0] PRESC_DIV64 = 2'h2;

   localparam int         PRESC_CNT_W = 6;
   localparam logic [5:0] DIV4_LAST   = 6'h03;
   localparam logic [5:0] DIV16_LAST  = 6'h0F;
   localparam logic [5:0] DIV32_LAST  = 6'h1F;
   localparam logic [5:0] DIV64_LAST  = 6'h3F;

   localparam logic [1:0] UART_MODE0 = 2'h0;
   localparam logic [1:0] UART_MODE2 = 2'h2;

endpackage

/* rtl/timer_tick_if.sv */
// Carries the shared prescaler code and the divided tick pulses.
// Assumes one clock; the pulses last one cycle.
`timescale 1ns/1ps
`default_nettype none

interface timer_tick_if;
   logic [1:0] presc_sel;
   logic       tick;
   logic       fix16;
   logic       fix32;

   modport src (input presc_sel, output tick, output fix16, output fix32);
   modport dst (output presc_sel, input tick, input fix16, input fix32);
endinterface

`default_nettype wire

/* rtl/timer_prescaler.sv */
// Free-running divider of the oscillator clock: shared timer tick and
// the fixed UART bit clocks. Assumes a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module timer_prescaler
   import timer2_pkg::*;
(
   input  wire logic   i_ref_clk,
   input  wire logic   i_rst,
   timer_tick_if.src   tk
);

   logic [PRESC_CNT_W-1:0] div_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 6'h01;
      end
   end

   // Reserved code gives no tick, so timer 2 holds unless it counts count pin edges
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         tk.tick <= 1'b0;
      end else begin
         unique case (tk.presc_sel)
            PRESC_DIV4:  tk.tick <= (div_q[1:0] == DIV4_LAST[1:0]);
            PRESC_DIV16: tk.tick <= (div_q[3:0] == DIV16_LAST[3:0]);
            PRESC_DIV64: tk.tick <= (div_q == DIV64_LAST);
            default:     tk.tick <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         tk.fix16 <= 1'b0;
         tk.fix32 <= 1'b0;
      end else begin
         tk.fix16 <= (div_q[3:0] == DIV16_LAST[3:0]);
         tk.fix32 <= (div_q[4:0] == DIV32_LAST[4:0]);
      end
   end

   sequence div4_gap_s;
      !tk.tick [*3] ##1 tk.tick;
   endsequence

   div4_tick_gap_a: assert property (@(posedge i_ref_clk)
      disable iff (i_rst || tk.presc_sel != PRESC_DIV4)
      tk.tick |=> div4_gap_s)
      else $error("prescaler tick not every 4 clocks");

   fixed_clock_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      tk.fix32 |-> tk.fix16 ##1 !tk.fix16 [*8])
      else $error("fixed bit clocks out of step");

endmodule

`default_nettype wire

/* rtl/ovf_toggle_pin.sv */
// One overflow toggle output with its pin source select.
// Assumes the overflow pulse comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ovf_toggle_pin (
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   input  wire logic i_ovf,
   input  wire logic i_out_sel,
   input  wire logic i_latch,
   output var  logic o_pin
);

   logic toggle_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         toggle_q <= 1'b0;
      end else if (i_ovf) begin
         toggle_q <= ~toggle_q;
      end
   end

   // Pin lags the toggle by one clock; keeps the output a plain flop
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_pin <= 1'b0;
      end else begin
         o_pin <= i_out_sel ? toggle_q : i_latch;
      end
   end

endmodule

`default_nettype wire

/* rtl/timer2_baud_clock_gen.sv */
// Timer 2 (capture, auto-reload up/down, baud generator), the shared
// prescaler, the timer 0/1 overflow toggle pins and UART clock selection.
// Assumes timer 0/1 overflow pulses and UART modes arrive on this clock;
// the external pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module timer2_baud_clock_gen
   import timer2_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic [10:0] i_sfr_addr,
   input  wire logic        i_sfr_wr,
   input  wire logic        i_sfr_rd,
   input  wire logic [7:0]  i_sfr_wdata,
   output var  logic [7:0]  o_sfr_rdata,
   input  wire logic        i_ext_capture_direction_pin,
   input  wire logic        i_t2_count_pin,
   input  wire logic [1:0]  i_timer_ovf,
   input  wire logic [1:0]  i_port_latch,
   output var  logic [1:0]  o_ovf_pin,
   input  wire logic        i_t2_irq_enable,
   output var  logic        o_t2_irq,
   input  wire logic [1:0]  i_uart_a_mode,
   input  wire logic [1:0]  i_uart_b_mode,
   output var  logic [3:0]  o_uart_clk
);

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode

   function automatic logic hit(input logic [10:0] addr, input logic [10:0] reg_addr);
      return addr == reg_addr;
   endfunction

   // UART clock: fixed divisions in modes 0 and 2, timer overflow otherwise
   function automatic logic uart_clk_pick(input logic [1:0] mode, input logic use_t2,
                                          input logic t1_ovf, input logic t2_ovf,
                                          input logic fix16, input logic fix32);
      if (mode == UART_MODE0) begin
         return fix16;
      end else if (mode == UART_MODE2) begin
         return fix32;
      end
      return use_t2 ? t2_ovf : t1_ovf;
   endfunction

   logic wr_ctrl;
   logic wr_mode;
   logic wr_presc;
   logic wr_status;
   logic wr_tl;
   logic wr_th;
   logic wr_rl;
   logic wr_rh;
   logic cnt_wr;

   assign wr_ctrl   = i_sfr_wr && hit(i_sfr_addr, TIMER2_CONTROL_ADDR);
   assign wr_mode   = i_sfr_wr && hit(i_sfr_addr, TIMER2_MODE_CONTROL_ADDR);
   assign wr_presc  = i_sfr_wr && hit(i_sfr_addr, SYSTEM_CONFIG_PRESCALER_ADDR);
   assign wr_status = i_sfr_wr && hit(i_sfr_addr, TIMER_EXTENDED_STATUS_ADDR);
   assign wr_tl     = i_sfr_wr && hit(i_sfr_addr, TIMER_LOW_BYTE_ADDR);
   assign wr_th     = i_sfr_wr && hit(i_sfr_addr, TIMER_HIGH_BYTE_ADDR);
   assign wr_rl     = i_sfr_wr && hit(i_sfr_addr, RELOAD_LOW_BYTE_ADDR);
   assign wr_rh     = i_sfr_wr && hit(i_sfr_addr, RELOAD_HIGH_BYTE_ADDR);
   assign cnt_wr    = wr_tl || wr_th;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0]  timer2_control_q;
   logic [7:0]  timer2_mode_control_q;
   logic [7:0]  system_config_prescaler_q;
   logic [7:0]  timer_extended_status_q;
   logic [15:0] cnt_q;
   logic [15:0] reload_q;
   logic        tf2_set;
   logic        external_event_flag_set;
   logic        ext_capture;

   // Hardware set is applied last so it wins over a software clear
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         timer2_control_q <= REG_RESET;
      end else begin
         if (wr_ctrl) begin
            timer2_control_q <= i_sfr_wdata;
         end
         if (tf2_set) begin
            timer2_control_q[OVF_FLAG_BIT] <= 1'b1;
         end
         if (external_event_flag_set) begin
            timer2_control_q[EXT_FLAG_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         timer2_mode_control_q     <= REG_RESET;
         system_config_prescaler_q <= REG_RESET;
         timer_extended_status_q   <= REG_RESET;
      end else begin
         if (wr_mode) begin
            timer2_mode_control_q <= i_sfr_wdata & MODE_MASK;
         end
         if (wr_presc) begin
            system_config_prescaler_q <= i_sfr_wdata & PRESC_MASK;
         end
         if (wr_status) begin
            timer_extended_status_q <= i_sfr_wdata & STATUS_MASK;
         end
      end
   end

   // Reload pair doubles as capture pair; a capture beats a software write
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         reload_q <= COUNT_RESET;
      end else if (ext_capture) begin
         reload_q <= cnt_q;
      end else begin
         if (wr_rl) begin
            reload_q[7:0] <= i_sfr_wdata;
         end
         if (wr_rh) begin
            reload_q[15:8] <= i_sfr_wdata;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_rd) begin
         unique case (i_sfr_addr)
            TIMER2_CONTROL_ADDR:          o_sfr_rdata <= timer2_control_q;
            TIMER2_MODE_CONTROL_ADDR:     o_sfr_rdata <= timer2_mode_control_q;
            SYSTEM_CONFIG_PRESCALER_ADDR: o_sfr_rdata <= system_config_prescaler_q;
            TIMER_EXTENDED_STATUS_ADDR:   o_sfr_rdata <= timer_extended_status_q;
            TIMER_LOW_BYTE_ADDR:          o_sfr_rdata <= cnt_q[7:0];
            TIMER_HIGH_BYTE_ADDR:         o_sfr_rdata <= cnt_q[15:8];
            RELOAD_LOW_BYTE_ADDR:         o_sfr_rdata <= reload_q[7:0];
            RELOAD_HIGH_BYTE_ADDR:        o_sfr_rdata <= reload_q[15:8];
            default:                      o_sfr_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: bit 0 direction/capture pin, bit 1 count pin

   logic [1:0] pin_meta_q;
   logic [1:0] pin_sync_q;
   logic [1:0] pin_prev_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pin_meta_q <= 2'h3;
         pin_sync_q <= 2'h3;
         pin_prev_q <= 2'h3;
      end else begin
         pin_meta_q <= {i_t2_count_pin, i_ext_capture_direction_pin};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   logic external_capture_direction_pin_fall;
   logic count_pin_fall;
   logic external_capture_direction_pin_level;

   assign external_capture_direction_pin_fall      = pin_prev_q[0] && !pin_sync_q[0];
   assign count_pin_fall = pin_prev_q[1] && !pin_sync_q[1];
   assign external_capture_direction_pin_level     = pin_sync_q[0];

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler

   timer_tick_if tk ();

   assign tk.presc_sel = system_config_prescaler_q[PRESC_LOW_BIT+:2];

   timer_prescaler u_prescaler (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .tk        (tk.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Timer 2 counter

   logic baud_mode;
   logic cap_mode;
   logic down;
   logic count_en;
   logic ovf_up;
   logic match_dn;
   logic ext_reload;
   logic down_en;
   logic ext_en;

   assign down_en  = timer2_mode_control_q[DOWN_EN_BIT];
   assign ext_en   = timer2_control_q[EXT_EN_BIT];
   // Any clock-select bit turns timer 2 into a baud generator
   assign baud_mode = timer2_control_q[UART_A_RX_BIT] || timer2_control_q[UART_A_TX_BIT]
                   || timer2_mode_control_q[UART_B_RX_BIT]
                   || timer2_mode_control_q[UART_B_TX_BIT];
   assign cap_mode  = timer2_control_q[CAP_RL_BIT] && !baud_mode;
   assign down      = !baud_mode && !cap_mode && down_en && !external_capture_direction_pin_level;

   always_comb begin
      count_en = 1'b0;
      if (timer2_control_q[RUN_BIT]) begin
         if (baud_mode) begin
            count_en = tk.tick;
         end else begin
            count_en = timer2_control_q[CT_SEL_BIT] ? count_pin_fall : tk.tick;
         end
      end
   end

   // Overflow at FFFFH up; in baud mode the reload makes the period 65536 minus the reload value
   assign ovf_up      = count_en && !down && (cnt_q == TIMER_MAX);
   assign match_dn    = count_en && down && (cnt_q == reload_q);
   assign ext_reload  = !baud_mode && !cap_mode && !down_en && ext_en && external_capture_direction_pin_fall;
   assign ext_capture = cap_mode && ext_en && external_capture_direction_pin_fall;
   // No overflow flag while generating baud clocks
   assign tf2_set     = (ovf_up || match_dn) && !baud_mode;
   assign external_event_flag_set    = ext_reload || ext_capture;

   // Software byte writes are applied last and override counting
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cnt_q <= COUNT_RESET;
      end else begin
         if (ovf_up && !cap_mode) begin
            cnt_q <= reload_q;
         end else if (match_dn) begin
            cnt_q <= TIMER_MAX;
         end else if (ext_reload) begin
            cnt_q <= reload_q;
         end else if (count_en) begin
            cnt_q <= down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
         end
         if (wr_tl) begin
            cnt_q[7:0] <= i_sfr_wdata;
         end
         if (wr_th) begin
            cnt_q[15:8] <= i_sfr_wdata;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_t2_irq <= 1'b0;
      end else begin
         o_t2_irq <= i_t2_irq_enable
                  && (timer2_control_q[OVF_FLAG_BIT] || timer2_control_q[EXT_FLAG_BIT]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // UART clocks: 0 uart a rx, 1 uart a tx, 2 uart b rx, 3 uart b tx

   logic [3:0] t2_route;

   assign t2_route = {timer2_mode_control_q[UART_B_TX_BIT], timer2_mode_control_q[UART_B_RX_BIT],
                      timer2_control_q[UART_A_TX_BIT], timer2_control_q[UART_A_RX_BIT]};

   // Each direction is routed on its own, so the UARTs stay independent
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_uart_clk <= 4'h0;
      end else begin
         for (int k = 0; k < 4; k++) begin
            o_uart_clk[k] <= uart_clk_pick((k < 2) ? i_uart_a_mode : i_uart_b_mode, t2_route[k],
                                           i_timer_ovf[1], ovf_up, tk.fix16, tk.fix32);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overflow toggle pins for timers 0 and 1

   logic [1:0] pin_sel;

   assign pin_sel = {timer_extended_status_q[T1_OUT_SEL_BIT], timer_extended_status_q[T0_OUT_SEL_BIT]};

   for (genvar g = 0; g < 2; g++) begin : g_toggle
      ovf_toggle_pin u_toggle (
         .i_ref_clk (i_ref_clk),
         .i_rst     (i_rst),
         .i_ovf     (i_timer_ovf[g]),
         .i_out_sel (pin_sel[g]),
         .i_latch   (i_port_latch[g]),
         .o_pin     (o_ovf_pin[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence capture_done_s(logic [15:0] snap);
      reload_q == snap && timer2_control_q[EXT_FLAG_BIT];
   endsequence

   ovf_flag_set_a: assert property (tf2_set |=> timer2_control_q[OVF_FLAG_BIT])
      else $error("overflow flag not set");

   baud_flag_quiet_a: assert property (baud_mode && !wr_ctrl && !timer2_control_q[OVF_FLAG_BIT]
      |=> !timer2_control_q[OVF_FLAG_BIT])
      else $error("overflow flag set in baud mode");

   capture_copy_a: assert property (ext_capture |=> capture_done_s($past(cnt_q)))
      else $error("capture did not copy count");

   auto_reload_a: assert property (ovf_up && !cap_mode && !cnt_wr |=> cnt_q == $past(reload_q))
      else $error("overflow did not reload");

   down_match_a: assert property (match_dn && !cnt_wr
      |=> cnt_q == TIMER_MAX && (baud_mode || timer2_control_q[OVF_FLAG_BIT]))
      else $error("down match did not load all ones");

   down_step_a: assert property (count_en && down && !match_dn && !cnt_wr
      |=> cnt_q == 16'($past(cnt_q) - 16'h0001))
      else $error("down count step wrong");

   ext_reload_a: assert property (ext_reload && !ovf_up && !cnt_wr
      |=> cnt_q == $past(reload_q) && timer2_control_q[EXT_FLAG_BIT])
      else $error("external reload missing");

   irq_follow_a: assert property (i_t2_irq_enable && timer2_control_q[EXT_FLAG_BIT] |=> o_t2_irq)
      else $error("interrupt not raised by external flag");

   mode0_clock_a: assert property (i_uart_a_mode == UART_MODE0 && tk.fix16
      |=> o_uart_clk[0] && o_uart_clk[1])
      else $error("mode 0 bit clock missing");

endmodule

`default_nettype wire

/* tb/pin_partner.sv */
// Far-side model: capture/direction pin, count pin, timer 0/1 overflow pulses.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
   input  wire logic       i_ref_clk,
   output var  logic       o_ext_pin,
   output var  logic       o_count_pin,
   output var  logic [1:0] o_timer_ovf
);
   // Pins idle high so no stray falling edge reaches the synchronisers
   initial begin
      o_ext_pin   = 1'b1;
      o_count_pin = 1'b1;
      o_timer_ovf = 2'h0;
   end

   task automatic drive_pin(input logic v);
      o_ext_pin = v;
   endtask

   task automatic drive_count(input logic v);
      o_count_pin = v;
   endtask

   // Overflow pulses last exactly one cycle, as the timers make them
   task automatic pulse_ovf(input int idx);
      o_timer_ovf[idx] = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_timer_ovf[idx] = 1'b0;
   endtask
endmodule

`default_nettype wire

/* tb/timer2_baud_clock_gen_tb_top.sv */
// Bench for the timer 2 / baud clock block: register calls and expected values.
// Assumes the register port and pin timing given with the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin fail_count++; $display("Error %s expected %h seen %h", nm, ex, gt); end end

module timer2_baud_clock_gen_tb_top import timer2_pkg::*;;
   logic        i_ref_clk, i_rst, i_sfr_wr, i_sfr_rd, i_t2_irq_enable;
   logic [10:0] i_sfr_addr;
   logic [7:0]  i_sfr_wdata, o_sfr_rdata;
   logic        ext_pin, count_pin, o_t2_irq;
   logic [1:0]  timer_ovf, i_port_latch, o_ovf_pin, i_uart_a_mode, i_uart_b_mode;
   logic [3:0]  o_uart_clk;
   int          fail_count = 0;
   int          n_checks = 0;
   // Count bytes come before control: all ones in control starts the timer
   logic [10:0] regs [9] = '{TIMER_EXTENDED_STATUS_ADDR, TIMER_LOW_BYTE_ADDR, TIMER_HIGH_BYTE_ADDR,
      RELOAD_LOW_BYTE_ADDR, RELOAD_HIGH_BYTE_ADDR, TIMER2_CONTROL_ADDR, TIMER2_MODE_CONTROL_ADDR,
      SYSTEM_CONFIG_PRESCALER_ADDR, 11'h7FF};
   logic [7:0]  masks [9] = '{STATUS_MASK, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, MODE_MASK, PRESC_MASK, 8'h00};

   timer2_baud_clock_gen DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
      .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
      .i_ext_capture_direction_pin(ext_pin), .i_t2_count_pin(count_pin), .i_timer_ovf(timer_ovf),
      .i_port_latch(i_port_latch), .o_ovf_pin(o_ovf_pin), .i_t2_irq_enable(i_t2_irq_enable),
      .o_t2_irq(o_t2_irq), .i_uart_a_mode(i_uart_a_mode), .i_uart_b_mode(i_uart_b_mode),
      .o_uart_clk(o_uart_clk));

   pin_partner P (.i_ref_clk(i_ref_clk), .o_ext_pin(ext_pin), .o_count_pin(count_pin),
      .o_timer_ovf(timer_ovf));

   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic end_sim();
      $display("Checks %0d, errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      #1;
      i_sfr_addr  = a;
      i_sfr_wdata = d;
      i_sfr_wr    = 1'b1;
      @(posedge i_ref_clk);
      #1;
      i_sfr_wr = 1'b0;
   endtask

   task automatic chk_reg(input logic [10:0] a, input logic [7:0] e);
      @(posedge i_ref_clk);
      #1;
      i_sfr_addr = a;
      i_sfr_rd   = 1'b1;
      @(posedge i_ref_clk);
      #1;
      i_sfr_rd = 1'b0;
      `CHK($sformatf("reg %h", a), e, o_sfr_rdata)
   endtask

   // Bounded wait for the interrupt; running out ends the run
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (o_t2_irq !== 1'b1 && n < lim) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      `CHK("irq", 1'b1, o_t2_irq)
      if (n >= lim) end_sim();
   endtask

   // First pass aligns to a pulse, second measures the spacing
   task automatic chk_period(input int b, input int per);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge i_ref_clk);
            #1;
            n++;
         end while (o_uart_clk[b] !== 1'b1 && n < 300);
      end
      `CHK($sformatf("uart clk %0d period", b), per, n)
      if (n >= 300) end_sim();
   endtask

   initial begin
      i_rst           = 1'b1;
      i_sfr_wr        = 1'b0;
      i_sfr_rd        = 1'b0;
      i_sfr_addr      = 11'h000;
      i_sfr_wdata     = 8'h00;
      i_t2_irq_enable = 1'b1;
      i_port_latch    = 2'h2;
      i_uart_a_mode   = 2'h0;
      i_uart_b_mode   = 2'h2;
      repeat (16) @(posedge i_ref_clk);
      #1;
      i_rst = 1'b0;
      for (int i = 0; i < 9; i++) begin
         chk_reg(regs[i], REG_RESET);
         wr(regs[i], 8'hFF);
         chk_reg(regs[i], masks[i]);
         wr(regs[i], 8'h00);
      end
      `CHK("ovf pin latch", 2'h2, o_ovf_pin)
      wr(TIMER_EXTENDED_STATUS_ADDR, 8'h01);
      i_port_latch = 2'h0;
      P.pulse_ovf(0);
      repeat (2) @(posedge i_ref_clk);
      #1;
      `CHK("ovf pin toggle", 2'h1, o_ovf_pin)
      ////////////////////////////////////////////////////////////////////////////////
      wr(SYSTEM_CONFIG_PRESCALER_ADDR, 8'h08);
      wr(RELOAD_LOW_BYTE_ADDR, 8'h34);
      wr(RELOAD_HIGH_BYTE_ADDR, 8'h12);
      wr(TIMER_LOW_BYTE_ADDR, 8'hFF);
      wr(TIMER_HIGH_BYTE_ADDR, 8'hFF);
      wr(TIMER2_CONTROL_ADDR, 8'h04);
      wait_irq(300);
      chk_reg(TIMER2_CONTROL_ADDR, 8'h84);
      wr(TIMER2_CONTROL_ADDR, 8'h00);
      chk_reg(TIMER_LOW_BYTE_ADDR, 8'h34);
      chk_reg(TIMER_HIGH_BYTE_ADDR, 8'h12);
      wr(TIMER2_MODE_CONTROL_ADDR, 8'h01);
      P.drive_pin(1'b0);
      wr(TIMER_LOW_BYTE_ADDR, 8'h36);
      wr(TIMER2_CONTROL_ADDR, 8'h04);
      wait_irq(400);
      chk_reg(TIMER2_CONTROL_ADDR, 8'h84);
      wr(TIMER2_CONTROL_ADDR, 8'h00);
      chk_reg(TIMER_LOW_BYTE_ADDR, 8'hFF);
      chk_reg(TIMER_HIGH_BYTE_ADDR, 8'hFF);
      ////////////////////////////////////////////////////////////////////////////////
      wr(TIMER2_MODE_CONTROL_ADDR, 8'h00);
      P.drive_pin(1'b1);
      wr(TIMER_LOW_BYTE_ADDR, 8'h55);
      wr(TIMER_HIGH_BYTE_ADDR, 8'h55);
      wr(TIMER2_CONTROL_ADDR, 8'h08);
      P.drive_pin(1'b0);
      wait_irq(20);
      chk_reg(TIMER2_CONTROL_ADDR, 8'h48);
      chk_reg(TIMER_LOW_BYTE_ADDR, 8'h34);
      chk_reg(TIMER_HIGH_BYTE_ADDR, 8'h12);
      wr(TIMER2_CONTROL_ADDR, 8'h00);
      P.drive_pin(1'b1);
      wr(TIMER_LOW_BYTE_ADDR, 8'hCD);
      wr(TIMER_HIGH_BYTE_ADDR, 8'hAB);
      wr(TIMER2_CONTROL_ADDR, 8'h09);
      P.drive_pin(1'b0);
      wait_irq(20);
      chk_reg(TIMER2_CONTROL_ADDR, 8'h49);
      chk_reg(RELOAD_LOW_BYTE_ADDR, 8'hCD);
      chk_reg(RELOAD_HIGH_BYTE_ADDR, 8'hAB);
      i_t2_irq_enable = 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1;
      `CHK("irq masked", 1'b0, o_t2_irq)
      i_t2_irq_enable = 1'b1;
      // Event counting: three falling edges on the count pin
      wr(TIMER2_CONTROL_ADDR, 8'h06);
      for (int i = 0; i < 6; i++) begin
         P.drive_count(i[0]);
         repeat (4) @(posedge i_ref_clk);
         #1;
      end
      chk_reg(TIMER_LOW_BYTE_ADDR, 8'hD0);
      ////////////////////////////////////////////////////////////////////////////////
      wr(TIMER2_CONTROL_ADDR, 8'h00);
      i_uart_a_mode = 2'h1;
      wr(RELOAD_LOW_BYTE_ADDR, 8'hFC);
      wr(RELOAD_HIGH_BYTE_ADDR, 8'hFF);
      wr(TIMER_LOW_BYTE_ADDR, 8'hFC);
      wr(TIMER_HIGH_BYTE_ADDR, 8'hFF);
      wr(SYSTEM_CONFIG_PRESCALER_ADDR, 8'h00);
      wr(TIMER2_CONTROL_ADDR, 8'h24);
      chk_period(0, 16);
      wr(SYSTEM_CONFIG_PRESCALER_ADDR, 8'h04);
      chk_period(0, 64);
      chk_reg(TIMER2_CONTROL_ADDR, 8'h24);
      i_uart_a_mode = 2'h3;
      chk_period(0, 64);
      P.pulse_ovf(1);
      `CHK("uart a tx from timer 1", 1'b1, o_uart_clk[1])
      i_uart_a_mode = 2'h0;
      chk_period(0, 16);
      chk_period(3, 32);
      i_uart_b_mode = 2'h0;
      chk_period(2, 16);
      end_sim();
   end
endmodule

`default_nettype wire
